// File: hw/synth_ctrl_pkg.sv
package synth_ctrl_pkg;
  // Register numbers on the programming port
  localparam logic [3:0] ADDR_FRAC_OUT = 4'h3;
  localparam logic [3:0] ADDR_FL_TIMING = 4'h4;
  localparam logic [3:0] ADDR_POWER = 4'h5;
  localparam logic [3:0] ADDR_FILTER = 4'h6;
  // Field positions, fraction and output setup
  localparam int WIDE_FRAC_BIT = 0;
  localparam int HALVER_BIT = 1;
  // Field positions, fastlock timing
  localparam int TOC_LSB = 0;
  localparam int FL_CUR_LSB = 14;
  localparam int NORM_CUR_LSB = 18;
  // Field positions, power and reset
  localparam int EN_LSB = 0;
  localparam int REG_RST_BIT = 7;
  // Field positions, loop filter
  localparam int CAP_LSB = 0;
  localparam int RES1_LSB = 3;
  localparam int RES2_LSB = 5;
  localparam int RES1_FL_LSB = 7;
  localparam int RES2_FL_LSB = 9;
  // Reset values
  localparam logic [23:0] RST_FRAC_OUT = 24'h000000;
  localparam logic [23:0] RST_FL_TIMING = 24'h000000;
  localparam logic [23:0] RST_POWER = 24'h00007f;
  localparam logic [23:0] RST_FILTER = 24'h000000;
  // Timeout codes
  localparam logic [13:0] TOC_HIZ = 14'h0000;
  localparam logic [13:0] TOC_FOREVER = 14'h0001;
  localparam logic [13:0] TOC_LOW = 14'h0002;
  localparam logic [13:0] TOC_HIGH = 14'h0003;
  localparam logic [13:0] TOC_MIN_COUNT = 14'h0004;
  // Widths
  localparam int FRAC_W = 22;
  localparam int FRAC_NARROW_W = 12;
  localparam int NUM_EN = 7;

  typedef struct packed {
    logic valid;
    logic [3:0] addr;
    logic [23:0] data;
  } reg_write_t;
endpackage

// File: hw/synth_fastlock_power_ctrl.sv
`timescale 1ns/10ps
// Operation
// - Wide fraction mode uses all 22 numerator and denominator bits.
// - Narrow fraction mode uses the low 12 bits and ignores the rest.
// - Halver select passes the oscillator at 0 and halves it at 1.
// - Timeout codes 0, 2 and 3 disable fastlock; pin is hi-Z, low or high.
// - A timeout code of 4 or more holds fastlock for twice the code.
// - Timeout code 1 drives the pin low and keeps fastlock engaged.
// - Counting grounds the pin and selects fast current and resistors.
// - In fastlock the pump multiplier is the fast current code plus one.
// - Each of seven block enables powers up at 1, down at 0, default 1.
// - A reset bit of 1 restores all defaults and powers the part down.
// - A next power write with reset 0 releases reset; blocks stay off.
// - Capacitor code selects its pF pair; codes 6 and 7 give 50/150.
// - Each resistor code selects 10, 20, 30 or 40 kilohm for 0 to 3.
module synth_fastlock_power_ctrl
  import synth_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire reg_write_t reg_wr,
  input wire logic pd_clk_pin,
  input wire logic [FRAC_W-1:0] frac_num_raw,
  input wire logic [FRAC_W-1:0] frac_den_raw,
  output logic [FRAC_W-1:0] frac_num_eff_ff,
  output logic [FRAC_W-1:0] frac_den_eff_ff,
  output logic osc_output_halver_sel_ff,
  output logic fastlock_pin_out_ff,
  output logic fastlock_pin_oe_ff,
  output logic fastlock_active_ff,
  output logic [4:0] pump_mult_ff,
  output logic [5:0] first_res_kohm_ff,
  output logic [5:0] second_res_kohm_ff,
  output logic [7:0] c3_pf_ff,
  output logic [7:0] c4_pf_ff,
  output logic [NUM_EN-1:0] block_power_ff,
  output logic reg_reset_active_ff
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] kohm(input logic [1:0] code);
    kohm = 6'((code + 3'h1) * 4'ha);
  endfunction

  function automatic logic [15:0] cap_pair(input logic [2:0] code);
    logic [15:0] p;
    p = 16'h3296;
    unique case (code)
      3'h0: p = 16'h3232;
      3'h1: p = 16'h3264;
      3'h2: p = 16'h3296;
      3'h3: p = 16'h6432;
      3'h4: p = 16'h9632;
      3'h5: p = 16'h6464;
      3'h6: p = 16'h3296;
      3'h7: p = 16'h3296;
    endcase
    cap_pair = p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [23:0] frac_out_ff, fl_timing_ff, power_ff, filter_ff;
  logic hold_off_ff;
  logic [14:0] cnt_ff;
  logic pd_s1_ff, pd_s2_ff, pd_s3_ff;

  wire wr_r3 = reg_wr.valid && reg_wr.addr == ADDR_FRAC_OUT;
  wire wr_r4 = reg_wr.valid && reg_wr.addr == ADDR_FL_TIMING;
  wire wr_r5 = reg_wr.valid && reg_wr.addr == ADDR_POWER;
  wire wr_r6 = reg_wr.valid && reg_wr.addr == ADDR_FILTER;
  wire rst_bit = reg_wr.data[REG_RST_BIT];
  wire reg_clear = wr_r5 && rst_bit;
  wire release_wr = wr_r5 && !rst_bit && reg_reset_active_ff;
  wire enable_wr = wr_r5 && !rst_bit && !reg_reset_active_ff;
  wire [13:0] new_toc = reg_wr.data[TOC_LSB +: 14];

  wire wide_q = frac_out_ff[WIDE_FRAC_BIT];
  wire halver_q = frac_out_ff[HALVER_BIT];
  wire [13:0] toc_q = fl_timing_ff[TOC_LSB +: 14];
  wire [3:0] fl_cur_q = fl_timing_ff[FL_CUR_LSB +: 4];
  wire [3:0] norm_cur_q = fl_timing_ff[NORM_CUR_LSB +: 4];
  wire [NUM_EN-1:0] en_q = power_ff[EN_LSB +: NUM_EN];
  wire [2:0] cap_q = filter_ff[CAP_LSB +: 3];
  wire pd_tick = pd_s2_ff && !pd_s3_ff;

  // Code 1 never expires; otherwise only a loaded count engages
  wire fl_active = (toc_q == TOC_FOREVER)
    || (cnt_ff != 15'h0000);

  wire [14:0] nxt_cnt = reg_clear ? 15'h0000 :
    wr_r4 ? ((new_toc >= TOC_MIN_COUNT) ? {new_toc, 1'b0} : 15'h0000) :
    (pd_tick && cnt_ff != 15'h0000) ? 15'(cnt_ff - 15'h0001) :
    cnt_ff;

  wire nxt_pin_oe = fl_active || toc_q == TOC_LOW || toc_q == TOC_HIGH;
  wire nxt_pin_out = !fl_active && toc_q == TOC_HIGH;

  wire [3:0] cur_sel = fl_active ? fl_cur_q : norm_cur_q;
  wire [1:0] res1_sel = fl_active ? filter_ff[RES1_FL_LSB +: 2] :
    filter_ff[RES1_LSB +: 2];
  wire [1:0] res2_sel = fl_active ? filter_ff[RES2_FL_LSB +: 2] :
    filter_ff[RES2_LSB +: 2];
  wire [15:0] caps = cap_pair(cap_q);

  // Upper bits ignored in narrow mode; saves the wide datapath power
  wire [FRAC_W-1:0] narrow_mask = {{(FRAC_W-FRAC_NARROW_W){1'b0}},
    {FRAC_NARROW_W{1'b1}}};
  wire [FRAC_W-1:0] frac_mask = wide_q ? {FRAC_W{1'b1}} : narrow_mask;
  wire [FRAC_W-1:0] nxt_num = frac_num_raw & frac_mask;
  wire [FRAC_W-1:0] nxt_den = frac_den_raw & frac_mask;
  wire [NUM_EN-1:0] nxt_power = hold_off_ff ? '0 : en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Phase detector clock is foreign; two stages before edge detect
  always_ff @(posedge ref_clk)
  begin
    pd_s1_ff <= rst_n && pd_clk_pin;
    pd_s2_ff <= rst_n && pd_s1_ff;
    pd_s3_ff <= rst_n && pd_s2_ff;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || reg_clear)
    begin
      frac_out_ff <= RST_FRAC_OUT;
      fl_timing_ff <= RST_FL_TIMING;
      power_ff <= RST_POWER;
      filter_ff <= RST_FILTER;
    end
    else
    begin
      if (wr_r3)
        frac_out_ff <= reg_wr.data;
      if (wr_r4)
        fl_timing_ff <= reg_wr.data;
      if (enable_wr)
        power_ff <= reg_wr.data;
      if (wr_r6)
        filter_ff <= reg_wr.data;
    end
  end

  // Part stays off from power-up until the enabling write
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hold_off_ff <= 1'b1;
      reg_reset_active_ff <= 1'b0;
      cnt_ff <= 15'h0000;
    end
    else
    begin
      hold_off_ff <= reg_clear || release_wr || (hold_off_ff && !enable_wr);
      reg_reset_active_ff <= reg_clear || (reg_reset_active_ff && !release_wr);
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      frac_num_eff_ff <= '0;
      frac_den_eff_ff <= '0;
      osc_output_halver_sel_ff <= 1'b0;
      fastlock_pin_out_ff <= 1'b0;
      fastlock_pin_oe_ff <= 1'b0;
      fastlock_active_ff <= 1'b0;
      pump_mult_ff <= 5'h01;
      first_res_kohm_ff <= 6'h0a;
      second_res_kohm_ff <= 6'h0a;
      c3_pf_ff <= 8'h32;
      c4_pf_ff <= 8'h32;
      block_power_ff <= '0;
    end
    else
    begin
      frac_num_eff_ff <= nxt_num;
      frac_den_eff_ff <= nxt_den;
      osc_output_halver_sel_ff <= halver_q;
      fastlock_pin_out_ff <= nxt_pin_out;
      fastlock_pin_oe_ff <= nxt_pin_oe;
      fastlock_active_ff <= fl_active;
      pump_mult_ff <= 5'(cur_sel + 5'h01);
      first_res_kohm_ff <= kohm(res1_sel);
      second_res_kohm_ff <= kohm(res2_sel);
      c3_pf_ff <= caps[15:8];
      c4_pf_ff <= caps[7:0];
      block_power_ff <= nxt_power;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  narrow_mask_a: assert property (!wide_q |=>
    frac_den_eff_ff[21:12] == '0
    && frac_den_eff_ff[11:0] == $past(frac_den_raw[11:0]))
    else $error("narrow fraction not masked");
  wide_pass_a: assert property (wide_q |=>
    frac_num_eff_ff == $past(frac_num_raw))
    else $error("wide fraction not passed");
  halver_out_a: assert property (
    ##1 osc_output_halver_sel_ff == $past(halver_q))
    else $error("halver select not applied");
  gpio_levels_a: assert property (toc_q == TOC_HIGH |=>
    fastlock_pin_oe_ff && fastlock_pin_out_ff)
    else $error("pin not driven high");
  gpio_hiz_a: assert property (toc_q == TOC_HIZ && cnt_ff == '0
    |=> !fastlock_pin_oe_ff) else $error("pin not floated");
  count_load_a: assert property (wr_r4 && !reg_clear
    && new_toc >= TOC_MIN_COUNT |=> cnt_ff == {$past(new_toc), 1'b0})
    else $error("timeout not doubled");
  forever_low_a: assert property (toc_q == TOC_FOREVER
    |=> fastlock_pin_oe_ff && !fastlock_pin_out_ff && fastlock_active_ff)
    else $error("code one not engaged");
  fast_mult_a: assert property (fl_active |=> pump_mult_ff ==
    5'($past(fl_cur_q) + 5'h01)) else $error("fastlock current wrong");
  expire_a: assert property (cnt_ff == 15'h0001 && pd_tick
    && !wr_r4 && !reg_clear && toc_q != TOC_FOREVER
    |-> ##2 !fastlock_active_ff)
    else $error("fastlock did not expire");
  power_down_a: assert property (reg_clear |->
    ##2 block_power_ff == '0)
    else $error("reset write did not power down");
  release_off_a: assert property (release_wr |->
    ##1 en_q == RST_POWER[6:0] ##1 block_power_ff == '0)
    else $error("release powered blocks");
  cap_map_a: assert property (cap_q == 3'h4 |=> c3_pf_ff == 8'h96
    && c4_pf_ff == 8'h32) else $error("capacitor pair wrong");
endmodule

// File: test/host_model.sv
`timescale 1ns/10ps
module host_model
  import synth_ctrl_pkg::*;
(
  input wire logic ref_clk,
  output reg_write_t reg_wr,
  output logic pd_clk_pin
);
  initial
  begin
    reg_wr = '0;
    pd_clk_pin = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // One word per write; released fields show junk, not the last word
  task automatic wr(input logic [3:0] a, input logic [23:0] d);
    @(negedge ref_clk);
    reg_wr = '{valid: 1'b1, addr: a, data: d};
    @(negedge ref_clk);
    reg_wr = '{valid: 1'b0, addr: ~a, data: ~d};
  endtask
  // Reset set, reset cleared, then power up
  task automatic init(input logic [6:0] en);
    wr(ADDR_POWER, 24'h000080);
    wr(ADDR_POWER, 24'h000000);
    wr(ADDR_POWER, 24'(en));
  endtask
  // Four cycles each level, so the synchroniser never misses an edge
  task automatic pd_pulse;
    repeat (4) @(negedge ref_clk);
    pd_clk_pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    pd_clk_pin = 1'b0;
  endtask
endmodule

// File: test/synth_fastlock_power_ctrl_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t got %h expected %h", $time, (g), (e)); end end
module synth_fastlock_power_ctrl_test
  import synth_ctrl_pkg::*;
;
  typedef struct {int id; logic [31:0] v;} note_t;
  logic ref_clk, rst_n, pd_clk_pin, output_halver_sel, pin_out, pin_oe, fl_act, rst_act;
  reg_write_t reg_wr;
  logic [FRAC_W-1:0] num_raw, den_raw, num_eff, den_eff;
  logic [4:0] pump;
  logic [5:0] res1, res2;
  logic [7:0] c3, c4;
  logic [NUM_EN-1:0] pwr;
  logic [31:0] rnd = 32'h00000046;
  logic [15:0] caps[8] = '{16'h3232, 16'h3264, 16'h3296, 16'h6432,
                           16'h9632, 16'h6464, 16'h3296, 16'h3296};
  logic [1:0] pins[4] = '{2'h0, 2'h2, 2'h2, 2'h3};
  int n_fail = 0;
  int cmp_count = 0;
  note_t q[$];
  note_t n;
  event look;
  //////////////////////////////////////////////////////////////////////
  host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr),
    .pd_clk_pin(pd_clk_pin));
  synth_fastlock_power_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .pd_clk_pin(pd_clk_pin), .frac_num_raw(num_raw),
    .frac_den_raw(den_raw), .frac_num_eff_ff(num_eff),
    .frac_den_eff_ff(den_eff), .osc_output_halver_sel_ff(output_halver_sel),
    .fastlock_pin_out_ff(pin_out), .fastlock_pin_oe_ff(pin_oe),
    .fastlock_active_ff(fl_act), .pump_mult_ff(pump),
    .first_res_kohm_ff(res1), .second_res_kohm_ff(res2), .c3_pf_ff(c3),
    .c4_pf_ff(c4), .block_power_ff(pwr), .reg_reset_active_ff(rst_act));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [5:0] kohm(input logic [1:0] c);
    return 6'(c) * 6'h0a + 6'h0a;
  endfunction
  function automatic logic [31:0] obs(input int id);
    case (id)
      0: return 32'(num_eff);
      1: return 32'(den_eff);
      2: return 32'(output_halver_sel);
      3: return 32'({pin_oe, pin_out});
      4: return 32'(fl_act);
      5: return 32'(pump);
      6: return 32'({res1, res2});
      7: return 32'({c3, c4});
      8: return 32'(pwr);
      default: return 32'(rst_act);
    endcase
  endfunction
  task automatic note(input int id, input logic [31:0] v);
    q.push_back('{id, v});
    ->look;
  endtask
  // Register, then derived output: two edges after the write
  task automatic settle;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  forever
  begin
    @(look);
    while (q.size() > 0)
    begin
      n = q.pop_front();
      `CHK(obs(n.id), n.v)
    end
  end
  initial
  begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    rst_n = 1'b0;
    num_raw = '0;
    den_raw = '0;
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    settle();
    note(8, 32'h0);
    note(7, 32'h3232);
    host.init(7'h7f);
    settle();
    note(8, 32'h7f);
    for (int i = 0; i < NUM_EN; i++)
    begin
      host.wr(ADDR_POWER, 24'(7'h7f ^ (7'h01 << i)));
      settle();
      note(8, 32'(7'h7f ^ (7'h01 << i)));
    end
    host.wr(ADDR_POWER, 24'h00007f);
    host.wr(4'h7, 24'h000000);
    settle();
    note(8, 32'h7f);
    for (int m = 0; m < 4; m++)
    begin
      host.wr(ADDR_FRAC_OUT, 24'(m));
      rnd = lfsr(rnd);
      num_raw = rnd[FRAC_W-1:0];
      rnd = lfsr(rnd);
      den_raw = rnd[FRAC_W-1:0];
      settle();
      note(0, 32'(m[0] ? num_raw : num_raw & 22'h000fff));
      note(1, 32'(m[0] ? den_raw : den_raw & 22'h000fff));
      note(2, 32'(m[1]));
    end
    for (int i = 0; i < 8; i++)
    begin
      host.wr(ADDR_FILTER, 24'({i[1:0], ~i[1:0], ~i[1:0], i[1:0], i[2:0]}));
      settle();
      note(6, 32'({kohm(i[1:0]), kohm(~i[1:0])}));
      note(7, 32'(caps[i]));
    end
    for (int c = 0; c < 4; c++)
    begin
      host.wr(ADDR_FL_TIMING, 24'(c));
      settle();
      note(3, 32'(pins[c]));
      note(4, 32'(c == 1));
    end
    // Code 1 must still be engaged after ten detector cycles
    host.wr(ADDR_FL_TIMING, 24'h000001);
    repeat (10) host.pd_pulse();
    note(4, 32'h1);
    for (int t = 4; t < 6; t++)
    begin
      host.wr(ADDR_FL_TIMING, 24'h0fc000 | 24'(t));
      settle();
      note(3, 32'h2);
      note(5, 32'h10);
      note(6, 32'h2a8);
      repeat (2 * t - 1) host.pd_pulse();
      note(4, 32'h1);
      host.pd_pulse();
      settle();
      note(4, 32'h0);
      note(3, 32'h0);
      note(5, 32'h4);
      note(6, 32'ha0a);
    end
    host.wr(ADDR_POWER, 24'h000080);
    settle();
    note(7, 32'h3232);
    note(5, 32'h1);
    note(8, 32'h0);
    note(9, 32'h1);
    // Enables in the release write must be dropped
    host.wr(ADDR_POWER, 24'h00007f);
    settle();
    note(9, 32'h0);
    note(8, 32'h0);
    @(negedge ref_clk);
    tally_and_finish();
  end
endmodule
